// >>> src/bvps_sequencer.sv
/*
  Startup, boot-voltage and output-good sequencer for a triple-output
  core-supply controller, with shutdown discharge and core-mode select.
  Assumes pins are asynchronous to clk_sys, that the serial command
  decoder and slew-rate setting sit on clk_sys, and that the analog
  loops follow target_mv.
*/
//
// Contract
// [R1] Boot pins decode to 1.1/1.0/0.9/0.8 V.
// [R2] Startup ramp runs at one millivolt per microsecond.
// [R3] Shutdown enables northbridge and core discharge switches.
// [R4] Boot code captured at first output-good only.
// [R5] Stored boot code cleared on shutdown release.
// [R6] Boot pins followed while both good signals low; code follows them only while off and in startup, not in the return states.
// [R7] Serial commands ignored until system-good goes high.
// [R8] System-good drop returns target to stored boot.
// [R9] Output-good low until boot reached plus 20us.
// [R10] Return slew uses the programmed slew rate.
// [R11] Later system-good rise keeps stored code.
// [R12] Output-good follows regulation status, not system-good.
// [R13] Second ground sense high selects unified mode.
// [R14] Second core shut down enables its discharge.
// [R15] Second core feedback pins high impedance in shutdown.
// [R16] Startup holds output-good low 20us after boot.
// [R17] Output-good released while slewing between codes.
// [R18] Stored boot code carries a valid flag.
// [R19] Control pins synchronised before sequencing.
`timescale 1ns/1ps
module bvps_sequencer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Control pins, asynchronous
  input wire logic power_down_bar,
  input wire logic system_good_in,
  input wire logic serial_vid_clock,
  input wire logic serial_vid_data,
  input wire logic remote_ground_sense_b_high,
  input wire logic regulation_ok,
  // Serial command and slew setting, on clk_sys
  input wire logic vid_cmd_valid,
  input wire logic [10:0] vid_cmd_mv,
  input wire logic [11:0] slew_cycles_per_mv,
  // Regulation target
  output logic [10:0] target_mv,
  output logic slewing,
  // Open-drain output-good pin
  output logic output_good_out,
  output logic output_good_oe,
  // Discharge and high-impedance controls
  output logic core_discharge_en,
  output logic nb_feedback_discharge_en,
  output logic neg_current_sense_b_discharge_en,
  output logic dc_feedback_b_oe,
  output logic ac_droop_out_b_oe,
  // Core mode
  output logic unified_mode,
  output logic ground_ref_is_a,
  // Boot status
  output logic svi_active,
  output logic [1:0] boot_code,
  output logic [1:0] stored_boot_code,
  output logic stored_boot_valid
);

  function automatic logic [10:0] boot_mv(input logic [1:0] code);
    case (code)
      2'h0: boot_mv = bvps_pkg::BOOT_MV_CODE0; // [R1]
      2'h1: boot_mv = bvps_pkg::BOOT_MV_CODE1; // [R1]
      2'h2: boot_mv = bvps_pkg::BOOT_MV_CODE2; // [R1]
      default: boot_mv = bvps_pkg::BOOT_MV_CODE3; // [R1]
    endcase
  endfunction : boot_mv

  logic [5:0] pins_s;
  logic pdb_s;
  logic sysgood_s;
  logic regok_s;
  logic pdb_q;
  logic sysgood_q;
  logic pdb_rise;
  logic sysgood_fall;
  logic [1:0] live_code;
  bvps_pkg::bvps_state_t state;
  bvps_pkg::bvps_state_t next_state;
  logic [10:0] dest_mv;
  logic [10:0] next_dest_mv;
  logic [11:0] step_cnt;
  logic [11:0] step_period;
  logic [9:0] hold_cnt;
  logic at_dest;
  logic hold_done;
  logic sysgood_seen;

  // Every pin goes through two flops before any decision reads it.
  bvps_sync #(
    .WIDTH(bvps_pkg::SYNC_W)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in({regulation_ok, remote_ground_sense_b_high,
               serial_vid_clock, serial_vid_data,
               system_good_in, power_down_bar}),
    .sync_out(pins_s)
  ); // [R19]

  assign pdb_s = pins_s[bvps_pkg::SY_PDB];
  assign sysgood_s = pins_s[bvps_pkg::SY_SYSGOOD];
  assign regok_s = pins_s[bvps_pkg::SY_REGOK];
  assign live_code = {pins_s[bvps_pkg::SY_SVC], pins_s[bvps_pkg::SY_SVD]};
  assign pdb_rise = pdb_s && !pdb_q;
  assign sysgood_fall = sysgood_q && !sysgood_s;
  assign at_dest = (target_mv == dest_mv);
  assign hold_done = (hold_cnt == bvps_pkg::GOOD_HOLD_CYCLES - 10'h001);

  // Only the startup ramp uses the fixed rate; a zero setting acts as one.
  always_comb begin
    if (state == bvps_pkg::ST_START_RAMP) begin
      step_period = bvps_pkg::STARTUP_CYCLES_PER_MV; // [R2]
    end else if (slew_cycles_per_mv == 12'h000) begin
      step_period = 12'h001;
    end else begin
      step_period = slew_cycles_per_mv; // [R10]
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pdb_q <= 1'b0;
      sysgood_q <= 1'b0;
    end else begin
      pdb_q <= pdb_s;
      sysgood_q <= sysgood_s;
    end
  end

  always_comb begin
    next_state = state;
    next_dest_mv = dest_mv;
    case (state)
      bvps_pkg::ST_OFF: begin
        next_dest_mv = bvps_pkg::TARGET_RESET;
        if (pdb_s) begin
          next_state = bvps_pkg::ST_START_RAMP;
          next_dest_mv = boot_mv(live_code);
        end
      end
      bvps_pkg::ST_START_RAMP: begin
        if (!sysgood_s) begin
          next_dest_mv = boot_mv(live_code); // [R6]
        end
        if (at_dest && next_dest_mv == dest_mv) begin
          next_state = bvps_pkg::ST_START_HOLD;
        end
      end
      bvps_pkg::ST_START_HOLD: begin
        if (!sysgood_s && boot_mv(live_code) != dest_mv) begin
          next_state = bvps_pkg::ST_START_RAMP; // [R6]
          next_dest_mv = boot_mv(live_code);
        end else if (hold_done) begin
          next_state = bvps_pkg::ST_RUN; // [R16]
        end
      end
      bvps_pkg::ST_RUN: begin
        if (sysgood_fall && sysgood_seen && stored_boot_valid) begin
          next_state = bvps_pkg::ST_RETURN_RAMP; // [R8]
          next_dest_mv = boot_mv(stored_boot_code); // [R8]
        end else if (vid_cmd_valid && sysgood_s && svi_active) begin
          next_dest_mv = vid_cmd_mv; // [R7]
        end
      end
      bvps_pkg::ST_RETURN_RAMP: begin
        if (at_dest) begin
          next_state = bvps_pkg::ST_RETURN_HOLD; // [R9]
        end
      end
      bvps_pkg::ST_RETURN_HOLD: begin
        if (hold_done) begin
          next_state = bvps_pkg::ST_RUN; // [R9]
        end
      end
      default: begin
        next_state = bvps_pkg::ST_OFF;
      end
    endcase
    if (!pdb_s) begin
      next_state = bvps_pkg::ST_OFF;
      next_dest_mv = bvps_pkg::TARGET_RESET;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= bvps_pkg::ST_OFF;
      dest_mv <= bvps_pkg::TARGET_RESET;
    end else begin
      state <= next_state;
      dest_mv <= next_dest_mv;
    end
  end

  // Target walks one millivolt per step period toward the destination.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      target_mv <= bvps_pkg::TARGET_RESET;
      step_cnt <= 12'h000;
    end else if (state == bvps_pkg::ST_OFF || !pdb_s) begin
      target_mv <= bvps_pkg::TARGET_RESET;
      step_cnt <= 12'h000;
    end else if (at_dest) begin
      step_cnt <= 12'h000;
    end else if (step_cnt >= step_period - 12'h001) begin
      step_cnt <= 12'h000;
      if (target_mv < dest_mv) begin
        target_mv <= target_mv + 11'h001; // [R2]
      end else begin
        target_mv <= target_mv - 11'h001; // [R10]
      end
    end else begin
      step_cnt <= step_cnt + 12'h001;
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hold_cnt <= 10'h000;
    end else if (state == bvps_pkg::ST_START_HOLD ||
                 state == bvps_pkg::ST_RETURN_HOLD) begin
      if (!hold_done) begin
        hold_cnt <= hold_cnt + 10'h001; // [R9]
      end
    end else begin
      hold_cnt <= 10'h000;
    end
  end

  // The boot pins are only looked at until the first output-good.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      boot_code <= bvps_pkg::BOOT_CODE_RESET;
    end else if (state == bvps_pkg::ST_OFF ||
                 ((state == bvps_pkg::ST_START_RAMP ||
                   state == bvps_pkg::ST_START_HOLD) && !sysgood_s)) begin
      boot_code <= live_code; // [R6]
    end
  end

  // A later system-good rise never touches the stored code.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stored_boot_code <= bvps_pkg::BOOT_CODE_RESET;
      stored_boot_valid <= 1'b0;
    end else if (pdb_rise) begin
      stored_boot_code <= bvps_pkg::BOOT_CODE_RESET; // [R5]
      stored_boot_valid <= 1'b0; // [R18]
    end else if (state == bvps_pkg::ST_START_HOLD &&
                 next_state == bvps_pkg::ST_RUN && !stored_boot_valid) begin
      stored_boot_code <= boot_code; // [R4]
      stored_boot_valid <= 1'b1; // [R18]
    end
  end // [R11]

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sysgood_seen <= 1'b0;
      svi_active <= 1'b0;
    end else if (!pdb_s) begin
      sysgood_seen <= 1'b0;
      svi_active <= 1'b0;
    end else begin
      if (state == bvps_pkg::ST_RUN && sysgood_s) begin
        sysgood_seen <= 1'b1;
      end
      svi_active <= sysgood_s && (next_state == bvps_pkg::ST_RUN); // [R7]
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      slewing <= 1'b0;
    end else begin
      slewing <= (next_state != bvps_pkg::ST_OFF) &&
                 (next_dest_mv != target_mv);
    end
  end

  // The pin only ever pulls low; released means good or slewing.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      output_good_out <= 1'b0;
      output_good_oe <= 1'b1;
    end else begin
      output_good_out <= 1'b0;
      case (next_state)
        bvps_pkg::ST_RUN: begin
          if (next_dest_mv != target_mv) begin
            output_good_oe <= 1'b0; // [R17]
          end else begin
            output_good_oe <= !regok_s; // [R12]
          end
        end
        bvps_pkg::ST_RETURN_RAMP: output_good_oe <= 1'b1; // [R9]
        bvps_pkg::ST_RETURN_HOLD: output_good_oe <= 1'b1; // [R9]
        bvps_pkg::ST_START_HOLD: output_good_oe <= 1'b1; // [R16]
        default: output_good_oe <= 1'b1;
      endcase
    end
  end

  // Shutdown switches; the second core is off whenever the part is down.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      core_discharge_en <= 1'b1;
      nb_feedback_discharge_en <= 1'b1;
      neg_current_sense_b_discharge_en <= 1'b1;
      dc_feedback_b_oe <= 1'b0;
      ac_droop_out_b_oe <= 1'b0;
    end else begin
      core_discharge_en <= !pdb_s; // [R3]
      nb_feedback_discharge_en <= !pdb_s; // [R3]
      neg_current_sense_b_discharge_en <= !pdb_s; // [R14]
      dc_feedback_b_oe <= pdb_s; // [R15]
      ac_droop_out_b_oe <= pdb_s; // [R15]
    end
  end

  // Mode is sampled while down and frozen at startup so it cannot flip
  // under load.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      unified_mode <= 1'b0;
      ground_ref_is_a <= 1'b0;
    end else if (state == bvps_pkg::ST_OFF) begin
      unified_mode <= pins_s[bvps_pkg::SY_GNDB]; // [R13]
      ground_ref_is_a <= pins_s[bvps_pkg::SY_GNDB]; // [R13]
    end
  end

endmodule : bvps_sequencer

// >>> src/bvps_pkg.sv
/*
  Shared constants for the boot-voltage and output-good sequencer.
  Assumes a 25 MHz system clock and target voltages counted in millivolts.
*/
package bvps_pkg;

  // System clock.
  localparam int unsigned CLK_PERIOD_NS = 40;

  // Startup ramp: one millivolt every microsecond.
  localparam int unsigned STARTUP_NS_PER_MV = 1000;
  localparam logic [11:0] STARTUP_CYCLES_PER_MV =
    12'((STARTUP_NS_PER_MV + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Extra output-good low time after the boot voltage is reached.
  localparam int unsigned GOOD_HOLD_US = 20;
  localparam logic [9:0] GOOD_HOLD_CYCLES =
    10'((GOOD_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Widths.
  localparam int unsigned MV_W = 11;
  localparam int unsigned SYNC_W = 6;

  // Boot voltages per two-bit boot code, in millivolts.
  localparam logic [10:0] BOOT_MV_CODE0 = 11'h44c;
  localparam logic [10:0] BOOT_MV_CODE1 = 11'h3e8;
  localparam logic [10:0] BOOT_MV_CODE2 = 11'h384;
  localparam logic [10:0] BOOT_MV_CODE3 = 11'h320;

  // Reset values.
  localparam logic [10:0] TARGET_RESET = 11'h000;
  localparam logic [1:0] BOOT_CODE_RESET = 2'h0;

  // Bit positions in the synchroniser vector.
  localparam int unsigned SY_PDB = 0;
  localparam int unsigned SY_SYSGOOD = 1;
  localparam int unsigned SY_SVD = 2;
  localparam int unsigned SY_SVC = 3;
  localparam int unsigned SY_GNDB = 4;
  localparam int unsigned SY_REGOK = 5;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_START_RAMP = 3'h1,
    ST_START_HOLD = 3'h2,
    ST_RUN = 3'h3,
    ST_RETURN_RAMP = 3'h4,
    ST_RETURN_HOLD = 3'h5
  } bvps_state_t;

endpackage : bvps_pkg

// >>> src/bvps_sync.sv
/*
  Two-flop synchroniser for a vector of independent pin levels.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/1ps
module bvps_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      sync_out <= '0;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : bvps_sync

// >>> sim/bvps_sequencer_properties.sv
/* Checker for bvps_sequencer, watching its ports only.
   Assumes a 25-cycle startup step and a 500-cycle output-good hold. */
`timescale 1ns/1ps
module bvps_seq_props (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Pins
  input wire logic power_down_bar,
  input wire logic system_good_in,
  input wire logic serial_vid_clock,
  input wire logic serial_vid_data,
  input wire logic regulation_ok,
  // Outputs
  input wire logic [10:0] target_mv,
  input wire logic slewing,
  input wire logic output_good_oe,
  input wire logic core_discharge_en,
  input wire logic nb_feedback_discharge_en,
  input wire logic neg_current_sense_b_discharge_en,
  input wire logic dc_feedback_b_oe,
  input wire logic svi_active,
  input wire logic [1:0] boot_code,
  input wire logic [1:0] stored_boot_code,
  input wire logic stored_boot_valid
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff reset;
  a_shut_discharge: assert property (!power_down_bar [*4] |->
    core_discharge_en && nb_feedback_discharge_en &&
    neg_current_sense_b_discharge_en && !dc_feedback_b_oe)
    else $error("discharge or hi-z missing in shutdown");
  a_boot_follow: assert property ((power_down_bar &&
    !system_good_in && !stored_boot_valid &&
    $stable({serial_vid_clock, serial_vid_data})) [*6]
    |-> boot_code == {serial_vid_clock, serial_vid_data})
    else $error("boot code not following pins");
  a_ramp_step: assert property (!stored_boot_valid &&
    target_mv > $past(target_mv) && target_mv > 11'h001 |->
    $past(target_mv, 25) == target_mv - 11'h001 &&
    $past(target_mv, 26) != target_mv - 11'h001)
    else $error("startup step not 25 cycles");
  a_capture_once: assert property ($rose(stored_boot_valid) |->
    stored_boot_code == boot_code && $past(target_mv, 255) == target_mv)
    else $error("bad boot capture");
  a_store_hold: assert property (stored_boot_valid |=>
    !stored_boot_valid || $stable(stored_boot_code))
    else $error("stored code changed");
  a_release_clear: assert property ($rose(power_down_bar) |->
    ##[2:4] !stored_boot_valid)
    else $error("stored code not cleared");
  a_slew_release: assert property (slewing && svi_active &&
    system_good_in |-> !output_good_oe)
    else $error("output-good held while slewing");
  a_drop_forces: assert property ($fell(system_good_in) &&
    svi_active |-> ##[2:4] output_good_oe [*8])
    else $error("output-good not forced low on drop");
  a_good_indep: assert property ((svi_active && system_good_in &&
    !slewing && $stable(regulation_ok)) [*5] |->
    output_good_oe == !regulation_ok)
    else $error("output-good not from regulation");
  c_capture: cover property ($rose(stored_boot_valid));
  c_command: cover property (slewing && svi_active);
  c_drop: cover property ($fell(system_good_in) && svi_active);
endmodule : bvps_seq_props
bind bvps_sequencer bvps_seq_props bvps_seq_props_inst (
  .clk_sys(clk_sys),
  .reset(reset),
  .power_down_bar(power_down_bar),
  .system_good_in(system_good_in),
  .serial_vid_clock(serial_vid_clock),
  .serial_vid_data(serial_vid_data),
  .regulation_ok(regulation_ok),
  .target_mv(target_mv),
  .slewing(slewing),
  .output_good_oe(output_good_oe),
  .core_discharge_en(core_discharge_en),
  .nb_feedback_discharge_en(nb_feedback_discharge_en),
  .neg_current_sense_b_discharge_en(neg_current_sense_b_discharge_en),
  .dc_feedback_b_oe(dc_feedback_b_oe),
  .svi_active(svi_active),
  .boot_code(boot_code),
  .stored_boot_code(stored_boot_code),
  .stored_boot_valid(stored_boot_valid)
);

// >>> sim/bvps_host_model.sv
/* System controller model on the far side of the sequencer.
   Assumes the bench asks it to power up, pick a boot code or drop good. */
`timescale 1ns/1ps
module bvps_host_model (
  // Clock
  input wire logic clk_sys,
  // Bench requests
  input wire logic run,
  input wire logic [1:0] boot,
  input wire logic drop,
  // Sequencer side
  input wire logic output_good_oe,
  output logic power_down_bar,
  output logic system_good_in,
  output logic serial_vid_clock,
  output logic serial_vid_data
);
  logic [1:0] div = 2'h0;
  initial begin
    power_down_bar = 1'b0;
    system_good_in = 1'b0;
    serial_vid_clock = 1'b0;
    serial_vid_data = 1'b0;
  end
  always @(posedge clk_sys) begin
    power_down_bar <= run;
    div <= div + 2'h1;
    if (!run || drop)
      system_good_in <= 1'b0;
    else if (!output_good_oe)
      system_good_in <= 1'b1;
    if (!system_good_in) begin
      serial_vid_clock <= boot[1];
      serial_vid_data <= boot[0];
    end else if (div == 2'h3) begin
      // Link traffic once boot pins are no longer read; 320 ns period.
      serial_vid_clock <= !serial_vid_clock;
      serial_vid_data <= !serial_vid_data;
    end
  end
endmodule : bvps_host_model

// >>> sim/tb_top.sv
/* Self-checking bench for bvps_sequencer with the controller model.
   Assumes the 25 MHz clock and the fixed startup and hold counts. */
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic regulation_ok = 1'b1;
  logic remote_ground_sense_b_high = 1'b0;
  logic vid_cmd_valid = 1'b0;
  logic [10:0] vid_cmd_mv = 11'h000;
  logic [11:0] slew_cycles_per_mv = 12'h002;
  logic run = 1'b0;
  logic [1:0] boot = 2'h0;
  logic drop = 1'b0;
  logic power_down_bar, system_good_in, serial_vid_clock, serial_vid_data;
  logic [10:0] target_mv;
  logic slewing, output_good_out, output_good_oe, svi_active;
  logic core_discharge_en, nb_feedback_discharge_en, unified_mode;
  logic neg_current_sense_b_discharge_en, dc_feedback_b_oe;
  logic ac_droop_out_b_oe, ground_ref_is_a, stored_boot_valid;
  logic [1:0] boot_code, stored_boot_code;
  int n_errors = 0;
  int n_tests = 0;
  int n;
  always #20 clk_sys = !clk_sys;
  bvps_sequencer bvps_sequencer_inst (
    .clk_sys(clk_sys),
    .reset(reset),
    .power_down_bar(power_down_bar),
    .system_good_in(system_good_in),
    .serial_vid_clock(serial_vid_clock),
    .serial_vid_data(serial_vid_data),
    .remote_ground_sense_b_high(remote_ground_sense_b_high),
    .regulation_ok(regulation_ok),
    .vid_cmd_valid(vid_cmd_valid),
    .vid_cmd_mv(vid_cmd_mv),
    .slew_cycles_per_mv(slew_cycles_per_mv),
    .target_mv(target_mv),
    .slewing(slewing),
    .output_good_out(output_good_out),
    .output_good_oe(output_good_oe),
    .core_discharge_en(core_discharge_en),
    .nb_feedback_discharge_en(nb_feedback_discharge_en),
    .neg_current_sense_b_discharge_en(neg_current_sense_b_discharge_en),
    .dc_feedback_b_oe(dc_feedback_b_oe),
    .ac_droop_out_b_oe(ac_droop_out_b_oe),
    .unified_mode(unified_mode),
    .ground_ref_is_a(ground_ref_is_a),
    .svi_active(svi_active),
    .boot_code(boot_code),
    .stored_boot_code(stored_boot_code),
    .stored_boot_valid(stored_boot_valid)
  );
  bvps_host_model bvps_host_model_inst (
    .clk_sys(clk_sys),
    .run(run),
    .boot(boot),
    .drop(drop),
    .output_good_oe(output_good_oe),
    .power_down_bar(power_down_bar),
    .system_good_in(system_good_in),
    .serial_vid_clock(serial_vid_clock),
    .serial_vid_data(serial_vid_data)
  );

  task tick(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : tick

  task check(input logic [10:0] seen, input logic [10:0] exp);
    #1;
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wait_mv(input logic [10:0] mv, input int lim);
    n = 0;
    while (target_mv !== mv && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    check(target_mv, mv);
  endtask : wait_mv

  task wait_good;
    n = 0;
    while (output_good_oe !== 1'b0 && n < 60) begin
      @(posedge clk_sys);
      n++;
    end
    // The pin data must stay low: the open-drain pin only ever pulls down.
    check({output_good_out, output_good_oe}, 11'h000);
  endtask : wait_good

  task cmd(input logic [10:0] mv);
    @(posedge clk_sys);
    vid_cmd_mv <= mv;
    vid_cmd_valid <= 1'b1;
    @(posedge clk_sys);
    vid_cmd_valid <= 1'b0;
  endtask : cmd

  task stop_test;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test

  initial begin
    tick(4);
    reset <= 1'b0;
    tick(3);
    check({core_discharge_en, nb_feedback_discharge_en,
      neg_current_sense_b_discharge_en, dc_feedback_b_oe,
      ac_droop_out_b_oe}, 11'h01c);
    for (int i = 0; i < 2; i++) begin
      tick(1);
      remote_ground_sense_b_high <= i[0];
      tick(6);
      check({unified_mode, ground_ref_is_a}, 11'(3 * i));
    end
    tick(1);
    run <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      tick(1);
      boot <= 2'(c);
      tick(6);
      check(boot_code, 11'(c));
    end
    wait_mv(11'h00a, 2000);
    wait_mv(11'h00c, 100);
    check(11'(n), 11'd50);
    wait_mv(11'h320, 25000);
    tick(480);
    check(output_good_oe, 11'h001);
    wait_good();
    check({stored_boot_valid, stored_boot_code}, 11'h007);
    cmd(11'h3e8);
    tick(20);
    check(target_mv, 11'h320);
    check(svi_active, 11'h001);
    // Regulation is out of window so only the slew can release the pin.
    tick(1);
    regulation_ok <= 1'b0;
    cmd(11'h3e8);
    tick(3);
    check({slewing, output_good_oe}, 11'h002);
    wait_mv(11'h3e8, 600);
    tick(2);
    check({slewing, boot_code}, 11'h003);
    check(output_good_oe, 11'h001);
    tick(1);
    regulation_ok <= 1'b1;
    tick(5);
    check(output_good_oe, 11'h000);
    tick(1);
    drop <= 1'b1;
    tick(6);
    check(output_good_oe, 11'h001);
    wait_mv(11'h320, 600);
    check(11'((n + 5) / 10), 11'd40);
    tick(480);
    check(output_good_oe, 11'h001);
    wait_good();
    tick(1);
    drop <= 1'b0;
    tick(10);
    check({stored_boot_valid, stored_boot_code}, 11'h007);
    tick(1);
    run <= 1'b0;
    tick(6);
    check({core_discharge_en, nb_feedback_discharge_en,
      neg_current_sense_b_discharge_en, dc_feedback_b_oe,
      ac_droop_out_b_oe}, 11'h01c);
    tick(1);
    run <= 1'b1;
    tick(6);
    check(stored_boot_valid, 11'h000);
    stop_test();
  end

  initial begin
    #1600000;
    n_errors++;
    stop_test();
  end
endmodule : tb_top
